// ==== design/lpoc_channel.sv ====
// lpoc_channel: one lamp output with its duty modulator and pin mapping
`timescale 1ns/10ps
`default_nettype none
module lpoc_channel
  import lpoc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // shared timebase
  lpoc_timing_if.chan     tb,
  // channel settings
  input  wire logic [7:0] channelDuty,
  input  wire logic [1:0] channelStateField,
  // pin
  output logic            pinOut,
  output logic            pinOe_n
);
  lpoc_chstate_e stateQ;
  logic [7:0]    dutyQ;
  logic          invQ;
  logic          drvQ;
  logic          periodEnd;
  logic          useDim;
  logic          indOn;
  logic          active;
  logic          pinLow;

  // settings apply only as a period starts
  assign periodEnd = tb.step && (tb.indCnt == 8'hFF);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stateQ <= LPOC_OFF;
      dutyQ  <= DUTY_RST;
      invQ   <= CTRL_RST[CTRL_INV_BIT];
      drvQ   <= CTRL_RST[CTRL_DRV_BIT];
    end else if (periodEnd) begin
      stateQ <= lpoc_chstate_e'(channelStateField);
      dutyQ  <= channelDuty;
      invQ   <= tb.outputInvert;
      drvQ   <= tb.outputDriveType;
    end
  end

  // modulation and combination
  assign useDim = (stateQ == LPOC_GRP) && !tb.dimOrBlinkSelect;
  assign indOn  = useDim ? (tb.indCnt[5:0] < dutyQ[7:2])
                         : (tb.indCnt < dutyQ);
  always_comb begin
    unique case (stateQ)
      LPOC_OFF: active = 1'b0;
      LPOC_ON:  active = 1'b1;
      LPOC_IND: active = indOn;
      LPOC_GRP: active = indOn && tb.grpOn;
    endcase
  end
  assign pinLow = active ^ invQ;

  // pin drive, frozen in sleep
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinOut  <= 1'b1;
      pinOe_n <= 1'b1;
    end else if (!tb.sleep) begin
      pinOut  <= !pinLow;
      pinOe_n <= !(pinLow || drvQ);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  open_drain_a: assert property (
    !drvQ && !tb.sleep |=> !(pinOut && !pinOe_n))
    else $error("upper transistor on in open-drain drive");
  sleep_hold_a: assert property (
    tb.sleep |=> $stable(pinOut) && $stable(pinOe_n))
    else $error("pin changed during sleep");
  on_state_a: assert property (
    stateQ == LPOC_ON && !invQ && !tb.sleep |=> !pinOut && !pinOe_n)
    else $error("on state did not drive low");
  shadow_hold_a: assert property (
    !periodEnd |=> $stable(dutyQ) && $stable(stateQ))
    else $error("channel setting changed mid-period");
endmodule
`default_nettype wire

// ==== design/lpoc_pkg.sv ====
// lpoc_pkg: constants and types of the LED output control block
package lpoc_pkg;
  // clock and timing figures
  localparam int  CLK_FREQ_HZ   = 200_000_000;
  localparam real IND_FREQ_KHZ  = 1.5625;
  localparam real DIM_FREQ_HZ   = 190.0;
  localparam real BLINK_MAX_HZ  = 24.0;
  localparam int  IND_STEPS     = 256;
  localparam int  DIM_STEPS     = 16;
  localparam int  GRP_STEPS     = 256;
  // cycles per step, rounded down
  localparam int  IND_STEP_CYC  =
    int'($floor(CLK_FREQ_HZ / (IND_FREQ_KHZ * 1000.0 * IND_STEPS)));
  localparam int  DIM_STEP_CYC  =
    int'($floor(CLK_FREQ_HZ / (DIM_FREQ_HZ * DIM_STEPS)));
  localparam int  BLINK_BASE_CYC =
    int'($floor(CLK_FREQ_HZ / (BLINK_MAX_HZ * GRP_STEPS)));
  // group periods up to this value blink at 6 Hz or faster
  localparam logic [7:0] FAST_BLINK_MAX = 8'h03;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] SEL_OFS    = 12'h004;
  localparam logic [11:0] DUTY0_OFS  = 12'h008;
  localparam logic [11:0] GDUTY_OFS  = 12'h018;
  localparam logic [11:0] GPER_OFS   = 12'h01C;
  localparam logic [11:0] STAT_OFS   = 12'h020;
  // control register field positions
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_INV_BIT   = 1;
  localparam int CTRL_DRV_BIT   = 2;
  localparam int CTRL_DMB_BIT   = 3;
  // reset values
  localparam logic [3:0] CTRL_RST  = 4'h4;
  localparam logic [7:0] SEL_RST   = 8'h00;
  localparam logic [7:0] DUTY_RST  = 8'h00;
  localparam logic [7:0] GDUTY_RST = 8'h00;
  localparam logic [7:0] GPER_RST  = 8'h00;
  // channel state codes
  typedef enum logic [1:0] {
    LPOC_OFF = 2'b00,
    LPOC_ON  = 2'b01,
    LPOC_IND = 2'b10,
    LPOC_GRP = 2'b11
  } lpoc_chstate_e;
endpackage

// ==== design/lpoc_timing_if.sv ====
// lpoc_timing_if: shared timebase from the top to the channels
`timescale 1ns/10ps
`default_nettype none
interface lpoc_timing_if;
  logic       step;
  logic [7:0] indCnt;
  logic       grpOn;
  logic       dimOrBlinkSelect;
  logic       outputInvert;
  logic       outputDriveType;
  logic       sleep;
  modport src (output step, indCnt, grpOn, dimOrBlinkSelect,
               outputInvert, outputDriveType, sleep);
  modport chan (input step, indCnt, grpOn, dimOrBlinkSelect,
                outputInvert, outputDriveType, sleep);
endinterface
`default_nettype wire

// ==== design/lpoc_top.sv ====
// lpoc_top: APB registers, timebase, group modulator and four channels
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - state 00 off/float or high, 01 on; invert swaps low and high
// - state 10 follows individual duty; open-drain low/float, else low/high
// - invert bit makes active time one minus the programmed duty
// - state 11 combines individual duty with the group signal
// - open-drain drive never switches on the upper transistor
// - individual duty at 1.5625 kHz with 256 steps
// - one group signal shared by all four outputs
// - dimming group signal is 190 Hz with 16 duty steps
// - blinking group period has 256 steps, 24 Hz down to 10.73 s (the code reaches about 10.67 s at most)
// - dimming: 64-step individual duty at 6.25 kHz, period ignored
// - fast blink 6 to 24 Hz: group duty in 64 steps
// - slow blink below 6 Hz: group duty in 256 steps
// - state 10 ignores selector, group duty and group period
// - sleep freezes outputs, no dimming or blinking
module lpoc_top
  import lpoc_pkg::*;
#(
  parameter int IND_CYC   = IND_STEP_CYC,
  parameter int DIM_CYC   = DIM_STEP_CYC,
  parameter int BLINK_CYC = BLINK_BASE_CYC
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // lamp pins
  output logic [3:0]       lampOutputPinOut,
  output logic [3:0]       lampOutputPinOe_n
);
  lpoc_timing_if tbus ();

  logic [3:0]  ctrlQ;
  logic [7:0]  selQ;
  logic [7:0]  dutyQ [4];
  logic [7:0]  gDutyQ;
  logic [7:0]  gPerQ;
  logic        mapped;
  logic        wrEn;
  logic        sleep;
  logic [31:0] rdMux;
  logic [8:0]  preQ;
  logic        step;
  logic [7:0]  indCntQ;
  logic [16:0] grpPreQ;
  logic [16:0] grpPreMax;
  logic        grpBase;
  logic [7:0]  grpDivQ;
  logic        grpStep;
  logic [7:0]  phaseQ;
  logic [7:0]  phaseD;
  logic        grpWrap;
  logic [7:0]  gDutyS;
  logic [7:0]  gPerS;
  logic        dimS;
  logic        grpOnQ;
  logic        fastBlink;

  assign sleep = ctrlQ[CTRL_SLEEP_BIT];

  // apb decode: zero wait states, unmapped answers an error
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFS:          rdMux = {28'h0, ctrlQ};
      SEL_OFS:           rdMux = {24'h0, selQ};
      DUTY0_OFS:         rdMux = {24'h0, dutyQ[0]};
      DUTY0_OFS + 12'h4: rdMux = {24'h0, dutyQ[1]};
      DUTY0_OFS + 12'h8: rdMux = {24'h0, dutyQ[2]};
      DUTY0_OFS + 12'hC: rdMux = {24'h0, dutyQ[3]};
      GDUTY_OFS:         rdMux = {24'h0, gDutyQ};
      GPER_OFS:          rdMux = {24'h0, gPerQ};
      STAT_OFS:          rdMux = {22'h0, grpOnQ, sleep,
                                  lampOutputPinOe_n, lampOutputPinOut};
      default:           mapped = 1'b0;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wrEn    = psel && penable && pwrite && mapped && pstrb[0];

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // control register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrlQ <= CTRL_RST;
    end else if (wrEn && paddr == CTRL_OFS) begin
      ctrlQ <= pwdata[3:0];
    end
  end

  // channel state and duty registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      selQ <= SEL_RST;
      for (int i = 0; i < 4; i++) begin
        dutyQ[i] <= DUTY_RST;
      end
    end else if (wrEn) begin
      if (paddr == SEL_OFS) begin
        selQ <= pwdata[7:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (paddr == DUTY0_OFS + 12'(4 * i)) begin
          dutyQ[i] <= pwdata[7:0];
        end
      end
    end
  end

  // group registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gDutyQ <= GDUTY_RST;
      gPerQ  <= GPER_RST;
    end else if (wrEn) begin
      if (paddr == GDUTY_OFS) begin
        gDutyQ <= pwdata[7:0];
      end
      if (paddr == GPER_OFS) begin
        gPerQ <= pwdata[7:0];
      end
    end
  end

  // individual step prescaler, stopped in sleep
  assign step = !sleep && (preQ == 9'(IND_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      preQ <= 9'h000;
    end else if (!sleep) begin
      preQ <= step ? 9'h000 : preQ + 9'h001;
    end
  end

  // individual phase counter shared by all channels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      indCntQ <= 8'h00;
    end else if (step) begin
      indCntQ <= indCntQ + 8'h01;
    end
  end

  // group step base: DIM_CYC in dimming, BLINK_CYC in blinking
  assign grpPreMax = dimS ? 17'(BLINK_CYC - 1)
                          : 17'(DIM_CYC - 1);
  assign grpBase   = !sleep && (grpPreQ >= grpPreMax);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      grpPreQ <= 17'h00000;
    end else if (!sleep) begin
      grpPreQ <= grpBase ? 17'h00000 : grpPreQ + 17'h00001;
    end
  end

  // blink period divider; dimming ignores the period
  assign grpStep = grpBase && (!dimS || grpDivQ >= gPerS);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      grpDivQ <= 8'h00;
    end else if (grpStep) begin
      grpDivQ <= 8'h00;
    end else if (grpBase) begin
      grpDivQ <= grpDivQ + 8'h01;
    end
  end

  // group phase: 16 steps in dimming, 256 in blinking
  assign phaseD  = phaseQ + (dimS ? 8'h01 : 8'h10);
  assign grpWrap = grpStep && (phaseD == 8'h00);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phaseQ <= 8'h00;
    end else if (grpStep) begin
      phaseQ <= phaseD;
    end
  end

  // group settings change only at a group period start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gDutyS <= GDUTY_RST;
      gPerS  <= GPER_RST;
      dimS   <= CTRL_RST[CTRL_DMB_BIT];
    end else if (grpWrap) begin
      gDutyS <= gDutyQ;
      gPerS  <= gPerQ;
      dimS   <= ctrlQ[CTRL_DMB_BIT];
    end
  end

  // group active phase at the resolution of the mode
  assign fastBlink = gPerS <= FAST_BLINK_MAX;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      grpOnQ <= 1'b0;
    end else if (!sleep) begin
      if (!dimS) begin
        grpOnQ <= phaseQ[7:4] < gDutyS[7:4];
      end else if (fastBlink) begin
        grpOnQ <= phaseQ[7:2] < gDutyS[7:2];
      end else begin
        grpOnQ <= phaseQ < gDutyS;
      end
    end
  end

  // timebase to the channels
  assign tbus.step             = step;
  assign tbus.indCnt           = indCntQ;
  assign tbus.grpOn            = grpOnQ;
  assign tbus.dimOrBlinkSelect = dimS;
  assign tbus.outputInvert     = ctrlQ[CTRL_INV_BIT];
  assign tbus.outputDriveType  = ctrlQ[CTRL_DRV_BIT];
  assign tbus.sleep            = sleep;

  // four channel outputs
  for (genvar g = 0; g < 4; g++) begin : gCh
    lpoc_channel uCh (
      .ref_clk           (ref_clk),
      .srst              (srst),
      .tb                (tbus.chan),
      .channelDuty       (dutyQ[g]),
      .channelStateField (selQ[2*g +: 2]),
      .pinOut            (lampOutputPinOut[g]),
      .pinOe_n           (lampOutputPinOe_n[g])
    );
  end

  // helper: cycles since last individual step
  logic [8:0] gapQ;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gapQ <= 9'h000;
    end else if (step) begin
      gapQ <= 9'h000;
    end else if (!sleep) begin
      gapQ <= gapQ + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence setupS;
    psel && !penable;
  endsequence
  sequence accessS;
    psel && penable;
  endsequence

  // timebase checks
  step_spacing_a: assert property (
    step |-> gapQ == 9'(IND_CYC - 1))
    else $error("individual step spacing wrong");
  ind_wrap_a: assert property (
    step && indCntQ == 8'hFF |=> indCntQ == 8'h00)
    else $error("individual counter did not wrap at 256");
  ind_hold_a: assert property (
    !step |=> $stable(indCntQ))
    else $error("individual counter moved between steps");
  sleep_freeze_a: assert property (
    sleep |=> $stable(indCntQ) && $stable(phaseQ) && $stable(grpOnQ))
    else $error("timebase moved during sleep");
  sleep_pre_a: assert property (
    sleep |=> $stable(preQ) && $stable(grpPreQ))
    else $error("prescalers ran during sleep");

  // group modulator checks
  dim_phase_a: assert property (
    grpStep && !dimS |=> phaseQ == $past(phaseQ) + 8'h10)
    else $error("dimming phase not 16 steps");
  dim_base_a: assert property (
    grpBase && !dimS |-> grpPreQ == 17'(DIM_CYC - 1))
    else $error("dimming step base overshot");
  dim_res_a: assert property (
    !sleep && !dimS && phaseQ[7:4] == gDutyS[7:4] |=> !grpOnQ)
    else $error("dimming duty not 16 steps");
  blink_div_a: assert property (
    grpBase && dimS && grpDivQ < gPerS |=> $stable(phaseQ))
    else $error("blink phase stepped before period");
  blink_phase_a: assert property (
    grpStep && dimS |=> phaseQ == $past(phaseQ) + 8'h01)
    else $error("blink phase not 256 steps");
  fast_res_a: assert property (
    !sleep && dimS && fastBlink && phaseQ[7:2] == gDutyS[7:2]
    |=> !grpOnQ)
    else $error("fast blink duty not 64 steps");
  slow_res_a: assert property (
    !sleep && dimS && !fastBlink && phaseQ < gDutyS |=> grpOnQ)
    else $error("slow blink duty not 256 steps");
  grp_load_a: assert property (
    !grpWrap |=> $stable(gDutyS) && $stable(gPerS) && $stable(dimS))
    else $error("group settings changed mid-period");
  grp_reload_a: assert property (
    grpWrap |=> gDutyS == $past(gDutyQ) && gPerS == $past(gPerQ))
    else $error("group settings not taken at wrap");

  // register bus checks
  apb_read_a: assert property (
    setupS ##1 accessS ##0 !pwrite |-> prdata == $past(rdMux) && pready)
    else $error("read data not from setup cycle");
  apb_err_a: assert property (
    accessS ##0 !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  apb_ok_a: assert property (
    accessS ##0 mapped |-> !pslverr && pready)
    else $error("mapped access flagged as error");
  ctrl_write_a: assert property (
    accessS ##0 (pwrite && pstrb[0] && paddr == CTRL_OFS)
    |=> ctrlQ == 4'($past(pwdata)))
    else $error("control write lost");
  strobe_block_a: assert property (
    accessS ##0 (pwrite && !pstrb[0])
    |=> $stable(ctrlQ) && $stable(selQ) && $stable(gDutyQ))
    else $error("write without strobe landed");
  err_data_a: assert property (
    setupS ##0 (!mapped && !pwrite) ##1 accessS |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  prdata_hold_a: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read setup");
endmodule
`default_nettype wire

// ==== tb/led_pwm_output_control_tb_top.sv ====
// testbench: registers, pin mapping, duty and group modulation, sleep
`timescale 1ns/10ps
`default_nettype none
module led_pwm_output_control_tb_top;
  import lpoc_pkg::*;
  // design signals
  logic        ref_clk;
  logic        srst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pinOut;
  logic [3:0]  pinOe_n;
  logic [3:0]  pinLevel;
  logic [3:0]  upperOn;
  // bench state
  int          mismatches;
  int          checks;
  int          upperBad = 0;
  logic        odWatch;
  logic [31:0] rd;
  logic        err;
  // rows: {invert, drive type, expected {oe_n,level} of ch1 and ch0}
  logic [5:0]  rows [4] = '{6'b01_0001, 6'b00_0011, 6'b11_0100, 6'b10_1100};

  // device under test with short step counts
  lpoc_top #(.IND_CYC(10), .DIM_CYC(40), .BLINK_CYC(20)) uut (
    .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lampOutputPinOut(pinOut), .lampOutputPinOe_n(pinOe_n));

  // lamps on the pins
  lpoc_lamp_load load (.pinOut(pinOut), .pinOe_n(pinOe_n),
    .pinLevel(pinLevel), .upperOn(upperOn));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // watch the upper transistor while open drain is in force
  always @(posedge ref_clk) begin
    if (odWatch && (upperOn !== 4'h0)) upperBad <= upperBad + 1;
  end

  // expected {oe_n, level} for an active phase, invert and drive type
  function automatic logic [1:0] pin_exp(input logic act, input logic inv,
                                         input logic drv);
    if (act ^ inv) return 2'b00;
    return drv ? 2'b01 : 2'b11;
  endfunction

  // seen {oe_n, level} of one channel
  function automatic logic [1:0] pin_seen(input int ch);
    return {pinOe_n[ch], pinLevel[ch]};
  endfunction

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic wr,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    @(posedge ref_clk);
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    pstrb   <= st;
    psel    <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      finish_test();
    end
  endtask

  // main sequence
  initial begin
    int n;
    int act;
    logic inv;
    logic drv;
    logic [7:0] snap;
    srst = 1'b1;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    mismatches = 0;
    checks = 0;
    odWatch = 1'b0;
    repeat (16) @(posedge ref_clk);
    check(pinOe_n, 4'hF, "pins float in reset");
    srst <= 1'b0;
    apb(CTRL_OFS, 1'b0, 32'h0, 4'hF);
    check(rd, 32'h4, "control reset value");
    apb(12'h040, 1'b0, 32'h0, 4'hF);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(DUTY0_OFS + 12'h004, 1'b1, 32'hAA, 4'h0);
    apb(DUTY0_OFS + 12'h004, 1'b0, 32'h0, 4'hF);
    check(rd, 32'h0, "write without strobe");
    // ch0 off, ch1 on, ch2 individual, ch3 group dimming
    apb(SEL_OFS, 1'b1, 32'hE4, 4'hF);
    apb(DUTY0_OFS + 12'h008, 1'b1, 32'h02, 4'hF);
    apb(DUTY0_OFS + 12'h00C, 1'b1, 32'hFF, 4'hF);
    apb(GDUTY_OFS, 1'b1, 32'h50, 4'hF);
    apb(DUTY0_OFS + 12'h00C, 1'b0, 32'h0, 4'hF);
    check(rd, 32'hFF, "duty read back");
    // one individual period for each invert and drive type pair
    for (int r = 0; r < 4; r++) begin
      inv = rows[r][5];
      drv = rows[r][4];
      apb(CTRL_OFS, 1'b1, {29'h0, drv, inv, 1'b0}, 4'hF);
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while ({pin_seen(1), pin_seen(0)} !== rows[r][3:0] && n < 3000);
      check({pin_seen(1), pin_seen(0)}, rows[r][3:0], "fixed states");
      if (n >= 3000) finish_test();
      odWatch = !drv;
      repeat (10) @(negedge ref_clk);
      check(pin_seen(2), pin_exp(1'b1, inv, drv), "duty on phase");
      repeat (100) @(negedge ref_clk);
      check(pin_seen(2), pin_exp(1'b0, inv, drv), "duty off phase");
      act = 0;
      repeat (1280) begin
        @(negedge ref_clk);
        if (pin_seen(3) === pin_exp(1'b1, inv, drv)) act++;
      end
      check(act, 400, "group dimming share");
      odWatch = 1'b0;
    end
    // fast blink: 22 of 64 phases per 5120 cycles, one 10-cycle gap may hit
    apb(GDUTY_OFS, 1'b1, 32'h5A, 4'hF);
    apb(CTRL_OFS, 1'b1, 32'hC, 4'hF);
    repeat (3000) @(negedge ref_clk);
    act = 0;
    repeat (5120) begin
      @(negedge ref_clk);
      if (pin_seen(3) === pin_exp(1'b1, 1'b0, 1'b1)) act++;
    end
    check(act >= 1750 && act <= 1760, 1'b1, "blink share");
    // sleep holds every pin and reads back as set in the status register
    apb(CTRL_OFS, 1'b1, 32'h3, 4'hF);
    repeat (4) @(negedge ref_clk);
    snap = {pinOe_n, pinOut};
    n = 0;
    repeat (1300) begin
      @(negedge ref_clk);
      if ({pinOe_n, pinOut} !== snap) n++;
    end
    check(n, 0, "pins frozen in sleep");
    apb(STAT_OFS, 1'b0, 32'h0, 4'hF);
    check(rd[8], 1'b1, "sleep status");
    check(upperBad, 0, "upper on in open drain");
    finish_test();
  end
endmodule
`default_nettype wire

// ==== tb/lpoc_lamp_load.sv ====
// lpoc_lamp_load: lamp load with pull-up resistor on each output pin
`timescale 1ns/10ps
`default_nettype none
module lpoc_lamp_load (
  // pins from the block
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe_n,
  // resolved wire level and upper transistor state
  output logic      [3:0] pinLevel,
  output logic      [3:0] upperOn
);
  // released pin is pulled to the supply by the lamp resistor
  assign pinLevel = pinOe_n | pinOut;
  // upper transistor conducts when driven high
  assign upperOn  = ~pinOe_n & pinOut;
endmodule
`default_nettype wire
